// ==== logic/aacr_pkg.sv ====
package aacr_pkg;
  // Register offsets on the control port
  localparam logic [7:0] OFS_BIAS     = 8'h0A;
  localparam logic [7:0] OFS_CH1_SLOT = 8'h0E;
  localparam logic [7:0] OFS_CH2_SLOT = 8'h0F;
  localparam logic [7:0] OFS_CH3_SLOT = 8'h10;
  localparam logic [7:0] OFS_CH4_SLOT = 8'h11;
  localparam logic [7:0] OFS_EN_HIGH  = 8'h16;
  localparam logic [7:0] OFS_EN_LOW   = 8'h17;
  localparam logic [7:0] OFS_RAMP     = 8'h1A;
  localparam logic [7:0] OFS_MUTE1    = 8'h1F;
  localparam logic [7:0] OFS_MUTE2    = 8'h20;
  localparam logic [7:0] OFS_AFE_1A   = 8'h29;
  localparam logic [7:0] OFS_AFE_1B   = 8'h2A;
  localparam logic [7:0] OFS_VOL_1A   = 8'h2B;
  localparam logic [7:0] OFS_VOL_1B   = 8'h2C;
  // Writable-bit masks, reserved bits read zero
  localparam logic [7:0] MASK_SLOT    = 8'hBF;
  localparam logic [7:0] MASK_BIAS    = 8'hF7;
  localparam logic [7:0] MASK_RAMP    = 8'h20;
  localparam logic [7:0] MASK_FULL    = 8'hFF;
  // Reset values
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_MUTE2    = 8'h80;
  // Field positions
  localparam int SLOT_STATE_BIT = 7;
  localparam int BIAS_PDN_LSB   = 4;
  localparam int BIAS_VPMIN_BIT = 2;
  localparam int RAMP_DIG_BIT   = 5;
  localparam int MUTE_POL_BIT   = 7;
  localparam int AFE_PRE_LSB    = 6;
  // Volume mute code
  localparam logic [7:0] VOL_MUTE_CODE = 8'h80;
  // Soft ramp step interval
  localparam int CLK_PERIOD_NS  = 5;
  localparam int RAMP_STEP_NS   = 1000;
  localparam int RAMP_STEP_CYC  = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Control port write/read request
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } aacr_req_t;
  // Serial-port slot steering
  typedef struct packed {
    logic       drive;  // Slot is driven by this device
    logic       valid;  // A channel starts in this slot
    logic [1:0] chan;   // Channel index 0..3
  } aacr_slot_t;
endpackage

// ==== logic/aacr_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module aacr_regs (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire aacr_pkg::aacr_req_t   REQ,
  output logic [7:0]                 RDATA,
  output logic                       RVALID,
  input  wire logic [5:0]            SLOT_INDEX,
  output aacr_pkg::aacr_slot_t       SLOT,
  output logic                       SDOUT_OE_N,
  input  wire logic                  MUTE_PIN,
  output logic                       MUTE_ACTIVE,
  output logic [7:0]                 PDN_FORCE,
  output logic [3:0]                 BIAS_EN,
  output logic [1:0]                 BIAS_LEVEL,
  output logic                       BIAS_MIN_SUPPLY,
  output logic [1:0]                 PREAMP_1A,
  output logic [5:0]                 PGA_1A,
  output logic [1:0]                 PREAMP_1B,
  output logic [5:0]                 PGA_1B,
  output logic [7:0]                 VOL_1A,
  output logic [7:0]                 VOL_1B,
  output logic [1:0]                 VOL_MUTE
);
  import aacr_pkg::*;

  logic [7:0] bias_reg;           // Bias control
  logic [7:0] slot_reg [4];       // Per-channel slot control
  logic [7:0] en_high_reg;        // Slot enables 8..15
  logic [7:0] en_low_reg;         // Slot enables 0..7
  logic [7:0] ramp_reg;           // Soft ramp control
  logic [7:0] mute1_reg;          // Mute pin power-down selects
  logic [7:0] mute2_reg;          // Mute pin polarity and selects
  logic [7:0] afe_reg [2];        // Front-end gain 1A/1B
  logic [7:0] vol_reg [2];        // Target digital volume 1A/1B
  logic [7:0] rd_next;            // Read mux
  logic       mute_meta_reg;      // Mute pin sync stage one
  logic       mute_sync_reg;      // Mute pin sync stage two
  logic [15:0] en_all;            // Combined slot enables
  aacr_slot_t slot_next;          // Slot steering next value
  logic [8:0] tick_cnt_reg;       // Ramp step divider
  logic       tick;               // Ramp step enable

  // Register writes, masked to writable bits
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bias_reg    <= RST_ZERO;
      for (int i = 0; i < 4; i++) slot_reg[i] <= RST_ZERO;
      en_high_reg <= RST_ZERO;
      en_low_reg  <= RST_ZERO;
      ramp_reg    <= RST_ZERO;
      mute1_reg   <= RST_ZERO;
      mute2_reg   <= RST_MUTE2;
      for (int i = 0; i < 2; i++) begin
        afe_reg[i] <= RST_ZERO;
        vol_reg[i] <= RST_ZERO;
      end
    end else if (REQ.wr) begin
      case (REQ.addr)
        OFS_BIAS:     bias_reg    <= REQ.wdata & MASK_BIAS;
        OFS_CH1_SLOT: slot_reg[0] <= REQ.wdata & MASK_SLOT;
        OFS_CH2_SLOT: slot_reg[1] <= REQ.wdata & MASK_SLOT;
        OFS_CH3_SLOT: slot_reg[2] <= REQ.wdata & MASK_SLOT;
        OFS_CH4_SLOT: slot_reg[3] <= REQ.wdata & MASK_SLOT;
        OFS_EN_HIGH:  en_high_reg <= REQ.wdata;
        OFS_EN_LOW:   en_low_reg  <= REQ.wdata;
        OFS_RAMP:     ramp_reg    <= REQ.wdata & MASK_RAMP;
        OFS_MUTE1:    mute1_reg   <= REQ.wdata;
        OFS_MUTE2:    mute2_reg   <= REQ.wdata;
        OFS_AFE_1A:   afe_reg[0]  <= REQ.wdata;
        OFS_AFE_1B:   afe_reg[1]  <= REQ.wdata;
        OFS_VOL_1A:   vol_reg[0]  <= REQ.wdata;
        OFS_VOL_1B:   vol_reg[1]  <= REQ.wdata;
        default: ;                                                // Unmapped: ignored
      endcase
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    case (REQ.addr)
      OFS_BIAS:     rd_next = bias_reg;
      OFS_CH1_SLOT: rd_next = slot_reg[0];
      OFS_CH2_SLOT: rd_next = slot_reg[1];
      OFS_CH3_SLOT: rd_next = slot_reg[2];
      OFS_CH4_SLOT: rd_next = slot_reg[3];
      OFS_EN_HIGH:  rd_next = en_high_reg;
      OFS_EN_LOW:   rd_next = en_low_reg;
      OFS_RAMP:     rd_next = ramp_reg;
      OFS_MUTE1:    rd_next = mute1_reg;
      OFS_MUTE2:    rd_next = mute2_reg;
      OFS_AFE_1A:   rd_next = afe_reg[0];
      OFS_AFE_1B:   rd_next = afe_reg[1];
      OFS_VOL_1A:   rd_next = vol_reg[0];
      OFS_VOL_1B:   rd_next = vol_reg[1];
      default:      rd_next = RST_ZERO;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RDATA  <= RST_ZERO;
      RVALID <= 1'b0;
    end else begin
      RVALID <= REQ.rd;
      if (REQ.rd) RDATA <= rd_next;
    end
  end

  // Slot steering for the serial output formatter
  assign en_all = {en_high_reg, en_low_reg};
  always_comb begin
    slot_next.drive = (SLOT_INDEX < 6'd16) ? en_all[SLOT_INDEX[3:0]] : 1'b0;
    slot_next.valid = 1'b0;
    slot_next.chan  = 2'd0;
    // Lowest channel wins if two share a start slot
    for (int c = 3; c >= 0; c--) begin
      if (slot_reg[c][5:0] == SLOT_INDEX && !slot_reg[c][SLOT_STATE_BIT]) begin
        slot_next.valid = 1'b1;
        slot_next.chan  = 2'(c);
      end
    end
  end

  // Slot outputs and serial enable, registered
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SLOT       <= '0;
      SDOUT_OE_N <= 1'b1;
    end else begin
      SLOT       <= slot_next;
      SDOUT_OE_N <= ~slot_next.drive;
    end
  end

  // Mute pin synchroniser
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mute_meta_reg <= 1'b0;
      mute_sync_reg <= 1'b0;
    end else begin
      mute_meta_reg <= MUTE_PIN;
      mute_sync_reg <= mute_meta_reg;
    end
  end

  // Mute polarity and forced power-downs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      MUTE_ACTIVE <= 1'b0;
      PDN_FORCE   <= 8'h00;
    end else begin
      MUTE_ACTIVE <= mute_sync_reg ~^ mute2_reg[MUTE_POL_BIT];
      PDN_FORCE   <= (mute_sync_reg ~^ mute2_reg[MUTE_POL_BIT]) ? mute1_reg : 8'h00;
    end
  end

  // Bias and front-end outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BIAS_EN         <= 4'h0;
      BIAS_LEVEL      <= 2'h0;
      BIAS_MIN_SUPPLY <= 1'b0;
      PREAMP_1A       <= 2'h0;
      PGA_1A          <= 6'h00;
      PREAMP_1B       <= 2'h0;
      PGA_1B          <= 6'h00;
    end else begin
      BIAS_EN         <= ~bias_reg[BIAS_PDN_LSB +: 4];
      BIAS_LEVEL      <= bias_reg[1:0];
      BIAS_MIN_SUPPLY <= bias_reg[BIAS_VPMIN_BIT];
      PREAMP_1A       <= afe_reg[0][AFE_PRE_LSB +: 2];
      PGA_1A          <= afe_reg[0][5:0];
      PREAMP_1B       <= afe_reg[1][AFE_PRE_LSB +: 2];
      PGA_1B          <= afe_reg[1][5:0];
    end
  end

  // Ramp step divider
  always_ff @(posedge CLK) begin
    if (!RST_N) tick_cnt_reg <= 9'h000;
    else if (tick) tick_cnt_reg <= 9'h000;
    else tick_cnt_reg <= tick_cnt_reg + 9'h001;
  end
  assign tick = (tick_cnt_reg == 9'(RAMP_STEP_CYC - 1));

  // Applied volume: jump or step one code per tick
  logic [7:0] vol_app [2];
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 2; i++) vol_app[i] <= RST_ZERO;
      VOL_MUTE <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        VOL_MUTE[i] <= (vol_reg[i] == VOL_MUTE_CODE);
        if (vol_reg[i] == VOL_MUTE_CODE) vol_app[i] <= vol_app[i];
        else if (!ramp_reg[RAMP_DIG_BIT]) vol_app[i] <= vol_reg[i];
        else if (tick && $signed(vol_app[i]) < $signed(vol_reg[i]))
          vol_app[i] <= vol_app[i] + 8'h01;
        else if (tick && $signed(vol_app[i]) > $signed(vol_reg[i]))
          vol_app[i] <= vol_app[i] - 8'h01;
      end
    end
  end
  assign VOL_1A = vol_app[0];
  assign VOL_1B = vol_app[1];

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_vol_write(int unsigned k);
    REQ.wr && REQ.addr == (k == 0 ? OFS_VOL_1A : OFS_VOL_1B);
  endsequence

  a_slot_drive_map: assert property (SLOT_INDEX < 6'd16 |=> SDOUT_OE_N == ~$past(en_all[SLOT_INDEX[3:0]]))
    else $error("slot enable mapping wrong");
  a_slot_hiz_high: assert property (SLOT_INDEX >= 6'd16 |=> SDOUT_OE_N)
    else $error("output driven in unmapped slot");
  a_chan_start: assert property (slot_reg[0][5:0] == SLOT_INDEX && !slot_reg[0][7] |=> SLOT.valid && SLOT.chan == 2'd0)
    else $error("channel one not started at its slot");
  a_chan_off: assert property (slot_reg[3][7] && slot_reg[0][5:0] != SLOT_INDEX && slot_reg[1][5:0] != SLOT_INDEX
    && slot_reg[2][5:0] != SLOT_INDEX |=> !SLOT.valid)
    else $error("disabled channel transmitted");
  a_mute_default: assert property (mute1_reg == 8'h00 |=> PDN_FORCE == 8'h00)
    else $error("mute touched power-downs");
  a_mute_polarity: assert property (mute2_reg[7] && mute_sync_reg |=> MUTE_ACTIVE)
    else $error("active-high mute not seen");
  a_bias_enable: assert property (REQ.wr && REQ.addr == OFS_BIAS ##1 1'b1 ##1 1'b1
    |-> BIAS_EN == ~$past(REQ.wdata[7:4], 2) && BIAS_LEVEL == $past(REQ.wdata[1:0], 2))
    else $error("bias outputs disagree with write");
  a_vol_mute_flag: assert property (s_vol_write(0) ##1 1'b1 |=> VOL_MUTE[0] == ($past(REQ.wdata, 2) == VOL_MUTE_CODE))
    else $error("volume mute flag wrong");
  a_ramp_gradual: assert property (ramp_reg[5] && !tick |=> $stable(VOL_1A))
    else $error("volume jumped under soft ramp");
  a_readback_ramp: assert property (REQ.rd && REQ.addr == OFS_RAMP |=> RVALID && RDATA == $past(ramp_reg))
    else $error("readback wrong");
endmodule // aacr_regs
`default_nettype wire

// ==== tb/aacr_regs_test.sv ====
`timescale 1ns/10ps
`default_nettype none
// Compare, count, report a mismatch
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module aacr_regs_test;
  import aacr_pkg::*;
  logic       clk;          // 200 MHz clock
  logic       rst_n;        // Synchronous reset
  aacr_req_t  req;          // Control port request
  logic [7:0] rdata;        // Read data
  logic       rvalid;       // Read data valid
  logic [5:0] slot_index;   // Current slot
  aacr_slot_t slot;         // Slot steering
  logic       sdout_oe_n;   // Serial output enable
  logic       mute_pin;     // Mute pin level
  logic       mute_active;  // Mute decoded
  logic [7:0] pdn_force;    // Forced power-downs
  logic [3:0] bias_en;      // Bias outputs on
  logic [1:0] bias_level;   // Bias level code
  logic       bias_min;     // Min supply select
  logic [1:0] pre_a, pre_b; // Preamp codes
  logic [5:0] pga_a, pga_b; // Gain codes
  logic [7:0] vol_a, vol_b; // Applied volumes
  logic [1:0] vol_mute;     // Volume mutes
  int         num_errors;   // Mismatches
  int         checks;       // Comparisons
  int         i;            // Loop index
  logic [7:0] ofs [14] = '{OFS_BIAS, OFS_CH1_SLOT, OFS_CH2_SLOT, OFS_CH3_SLOT, OFS_CH4_SLOT, OFS_EN_HIGH,
    OFS_EN_LOW, OFS_RAMP, OFS_MUTE1, OFS_MUTE2, OFS_AFE_1A, OFS_AFE_1B, OFS_VOL_1A, OFS_VOL_1B};
  logic [7:0] msk [14] = '{MASK_BIAS, MASK_SLOT, MASK_SLOT, MASK_SLOT, MASK_SLOT, MASK_FULL, MASK_FULL,
    MASK_RAMP, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL};

  aacr_regs dut (.CLK(clk), .RST_N(rst_n), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
    .SLOT_INDEX(slot_index), .SLOT(slot), .SDOUT_OE_N(sdout_oe_n), .MUTE_PIN(mute_pin),
    .MUTE_ACTIVE(mute_active), .PDN_FORCE(pdn_force), .BIAS_EN(bias_en), .BIAS_LEVEL(bias_level),
    .BIAS_MIN_SUPPLY(bias_min), .PREAMP_1A(pre_a), .PGA_1A(pga_a), .PREAMP_1B(pre_b), .PGA_1B(pga_b),
    .VOL_1A(vol_a), .VOL_1B(vol_b), .VOL_MUTE(vol_mute));

  // Free-running clock
  always #2.5 clk = ~clk;

  // One register write, held for one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    req.wr = 1'b1; req.addr = a; req.wdata = d;
    @(posedge clk); #1;
    req.wr = 1'b0;
  endtask

  // One register read, answer one cycle later
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); #1;
    req.rd = 1'b1; req.addr = a;
    @(posedge clk); #1;
    req.rd = 1'b0;
    `CHECK(rvalid, 1'b1)
    `CHECK(rdata, e)
  endtask

  // Let registered outputs catch up
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Counts and verdict, the single exit
  task automatic print_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #(20000 * 5);
    num_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    clk = 1'b0; rst_n = 1'b0; req = '0; slot_index = 6'h00; mute_pin = 1'b0;
    num_errors = 0; checks = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHECK(sdout_oe_n, 1'b1)
    for (i = 0; i < 14; i++) rd_chk(ofs[i], (ofs[i] == OFS_MUTE2) ? RST_MUTE2 : RST_ZERO);
    rd_chk(8'h05, 8'h00);
    $display("reset values done");
    // Default polarity: high pin mutes, no power-downs forced
    mute_pin = 1'b1;
    settle(4);
    `CHECK({mute_active, pdn_force}, {1'b1, 8'h00})
    wr_reg(OFS_MUTE1, 8'h5A);
    settle(2);
    `CHECK(pdn_force, 8'h5A)
    wr_reg(OFS_MUTE2, 8'h00);
    settle(2);
    `CHECK({mute_active, pdn_force}, {1'b0, 8'h00})
    $display("mute pin done");
    // Bias, gain front end
    wr_reg(OFS_BIAS, 8'h06);
    wr_reg(OFS_AFE_1A, 8'h40);
    wr_reg(OFS_AFE_1B, 8'h7F);
    settle(2);
    `CHECK({bias_en, bias_level, bias_min}, {4'hF, 2'h2, 1'b1})
    `CHECK({pre_a, pga_a, pre_b, pga_b}, {2'h1, 6'h00, 2'h1, 6'h3F})
    wr_reg(OFS_BIAS, 8'hA1);
    settle(2);
    `CHECK({bias_en, bias_level, bias_min}, {4'h5, 2'h1, 1'b0})
    $display("bias and gain done");
    // Slot map 0/3/6/9, slots 0..11 enabled
    wr_reg(OFS_CH1_SLOT, 8'h00);
    wr_reg(OFS_CH2_SLOT, 8'h03);
    wr_reg(OFS_CH3_SLOT, 8'h06);
    wr_reg(OFS_CH4_SLOT, 8'h09);
    wr_reg(OFS_EN_HIGH, 8'h0F);
    wr_reg(OFS_EN_LOW, 8'hFF);
    for (i = 0; i < 18; i++) begin
      @(posedge clk); #1 slot_index = 6'(i);
      settle(1);
      `CHECK({slot.drive, sdout_oe_n}, {i < 12, !(i < 12)})
      `CHECK(slot.valid, (i % 3 == 0) && (i <= 9))
      if (i % 3 == 0 && i <= 9) `CHECK(slot.chan, 2'(i / 3))
    end
    // Channel three withdrawn by its state flag
    wr_reg(OFS_CH3_SLOT, 8'h86);
    @(posedge clk); #1 slot_index = 6'd6;
    settle(2);
    `CHECK(slot.valid, 1'b0)
    $display("slot steering done");
    // Volume without ramp, then mute code
    wr_reg(OFS_VOL_1A, 8'h10);
    settle(2);
    `CHECK(vol_a, 8'h10)
    wr_reg(OFS_VOL_1A, 8'h00);
    settle(2);
    `CHECK(vol_a, 8'h00)
    wr_reg(OFS_VOL_1A, VOL_MUTE_CODE);
    settle(2);
    `CHECK(vol_mute, 2'b01)
    // Ramped change must step, not jump
    wr_reg(OFS_RAMP, 8'h20);
    wr_reg(OFS_VOL_1B, 8'h04);
    settle(100);
    `CHECK(vol_b == 8'h04, 1'b0)
    for (i = 0; i < 1500 && vol_b !== 8'h04; i++) settle(1);
    `CHECK(vol_b, 8'h04)
    $display("volume done");
    // Full write, reserved bits read zero
    for (i = 0; i < 14; i++) wr_reg(ofs[i], 8'hFF);
    wr_reg(8'h05, 8'hFF);
    for (i = 0; i < 14; i++) rd_chk(ofs[i], msk[i]);
    rd_chk(8'h05, 8'h00);
    $display("read back done");
    print_verdict();
  end
endmodule // aacr_regs_test
`default_nettype wire
